// file: rtl/adc_pkg.sv
// Constants for the converter sequencing and readout block
package adc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RES_WIDTH = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 8;

   function automatic int ceil_cyc(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction : ceil_cyc

   // Conversion and busy timing
   localparam int BUSY_MAX_NS = 1250;
   localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;
   localparam int CONV_CYC = BUSY_MAX_CYC - 10;
   localparam int EOC_TO_BUSY_NS = 10;
   localparam int DATA_TO_BUSY_NS = 12;
   localparam int DATA_TO_BUSY_CYC = ceil_cyc(DATA_TO_BUSY_NS);
   localparam int SYNC_DURING_NS = 525;
   localparam int SYNC_DURING_CYC = SYNC_DURING_NS / CLK_PERIOD_NS;
   localparam int SYNC_TO_BUSY_NS = 25;
   localparam int SYNC_TO_BUSY_CYC = ceil_cyc(SYNC_TO_BUSY_NS);

   // Serial clock phase minima per divider code 00..11
   localparam int SCLK_HIGH_MIN_NS [4] = '{12, 22, 50, 100};
   localparam int SCLK_LOW_MIN_NS [4] = '{7, 21, 49, 99};
   localparam int SYNC_LEAD_MIN_NS [4] = '{3, 17, 17, 17};
   localparam int SYNC_TAIL_MIN_NS [4] = '{3, 55, 130, 290};

   typedef enum logic [3:0] {
      CONV_IDLE = 4'h1,
      CONV_RUN = 4'h2,
      CONV_LOAD = 4'h4,
      CONV_TAIL = 4'h8
   } conv_state_t;

   typedef enum logic [6:0] {
      SER_IDLE = 7'h01,
      SER_LEAD = 7'h02,
      SER_HIGH = 7'h04,
      SER_LOW = 7'h08,
      SER_TAIL = 7'h10,
      SER_BUSY = 7'h20,
      SER_SLAVE = 7'h40
   } ser_state_t;
endpackage : adc_pkg

// file: rtl/adc_conversion_readout_timing.sv
// Converter sequencing, result buffer and parallel/serial readout
`timescale 1ns/10ps
`default_nettype none

module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign push = wr_valid_in && wr_ready_out;
   assign pop = rd_valid_out && rd_ready_in;
   assign wr_ready_out = (count_r != (AW + 1)'(DEPTH));
   assign rd_valid_out = (count_r != '0);
   assign rd_data_out = mem[rd_ptr_r];

   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem[wr_ptr_r] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : result_fifo

// Operation
// - Busy rises within 35 ns of start
// - Busy at most 1.25 us outside read-after
// - Parallel data valid within 1.25 us
// - Data valid 12 ns before busy falls
// - Busy falls 10 ns after conversion end
// - Bus driven within 45 ns, released 5-15 ns
// - Read-during frame starts 525 ns after start
// - Read-after frame starts at conversion end
// - Read-after busy falls 25 ns after frame
// - Read-during serial clock 25-40 ns period
// - Divider code sets minimum clock period
// - Divider code sets maximum clock period
// - Read-after busy width bounded per code
// - First clock edge lags frame marker
// - Frame marker held after last edge
// - Chip select high floats serial outputs
// - Slave data updates 3-18 ns after edge
// - Sixteen-bit result without pipeline delay
module adc_conversion_readout_timing
   import adc_pkg::*;
#(
   parameter int WIDTH = RES_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic conversion_start_n_in,
   input wire logic [WIDTH-1:0] sample_data_in,
   input wire logic serial_mode_in,
   input wire logic slave_mode_in,
   input wire logic read_after_in,
   input wire logic [1:0] clock_divider_select_in,
   input wire logic cs_n_in,
   input wire logic rd_n_in,
   input wire logic ext_sclk_in,
   input wire logic serial_data_in,
   output logic busy_out,
   output logic [WIDTH-1:0] data_out,
   output logic data_oe_out,
   output logic sync_out,
   output logic sync_oe_out,
   output logic sclk_out,
   output logic sclk_oe_out,
   output logic serial_data_out,
   output logic serial_data_oe_out
);
   conv_state_t conv_state_r;
   ser_state_t ser_state_r;
   logic start_n_prev_r;
   logic ext_sclk_prev_r;
   logic [CNT_W-1:0] conv_cnt_r;
   logic [CNT_W-1:0] ser_cnt_r;
   logic [4:0] bit_cnt_r;
   logic [WIDTH-1:0] sample_r;
   logic [WIDTH-1:0] result_r;
   logic [WIDTH-1:0] shreg_r;
   logic [1:0] div_r;
   logic push_r;
   logic loaded_r;
   logic handover_r;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic [WIDTH-1:0] fifo_rd_data;
   logic fifo_rd_ready;
   logic start_evt;
   logic master_mode;
   logic frame_during;
   logic frame_after;
   logic conv_done;
   logic ser_done;
   logic [CNT_W-1:0] high_cyc;
   logic [CNT_W-1:0] low_cyc;
   logic [CNT_W-1:0] lead_cyc;
   logic [CNT_W-1:0] tail_cyc;

   // Start is refused while converting or while the buffer is full
   assign start_evt = start_n_prev_r && !conversion_start_n_in
      && conv_state_r == CONV_IDLE && fifo_wr_ready;
   assign master_mode = serial_mode_in && !slave_mode_in;
   assign frame_during = master_mode && !read_after_in && !cs_n_in
      && conv_state_r == CONV_RUN && conv_cnt_r == CNT_W'(SYNC_DURING_CYC);
   assign frame_after = master_mode && read_after_in && !cs_n_in && loaded_r;
   assign conv_done = conv_state_r == CONV_TAIL && conv_cnt_r == '0;
   assign ser_done = ser_state_r == SER_BUSY && ser_cnt_r == '0;
   // Buffer drains only while no master serial frame is using the held result (idle or slave)
   assign fifo_rd_ready = ser_state_r == SER_IDLE || ser_state_r == SER_SLAVE;

   // Read-during always runs at the fastest divider setting
   always_comb begin
      high_cyc = CNT_W'(ceil_cyc(SCLK_HIGH_MIN_NS[div_r]));
      low_cyc = CNT_W'(ceil_cyc(SCLK_LOW_MIN_NS[div_r]));
      lead_cyc = CNT_W'(ceil_cyc(SYNC_LEAD_MIN_NS[div_r]));
      tail_cyc = CNT_W'(ceil_cyc(SYNC_TAIL_MIN_NS[div_r]));
   end

   result_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .wr_data_in(sample_r),
      .wr_valid_in(push_r),
      .wr_ready_out(fifo_wr_ready),
      .rd_data_out(fifo_rd_data),
      .rd_valid_out(fifo_rd_valid),
      .rd_ready_in(fifo_rd_ready)
   );

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         start_n_prev_r <= 1'b1;
         ext_sclk_prev_r <= 1'b0;
      end else begin
         start_n_prev_r <= conversion_start_n_in;
         ext_sclk_prev_r <= ext_sclk_in;
      end
   end

   // Conversion sequencing
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         conv_state_r <= CONV_IDLE;
         conv_cnt_r <= '0;
         sample_r <= '0;
         push_r <= 1'b0;
         handover_r <= 1'b0;
      end else begin
         push_r <= 1'b0;
         unique case (conv_state_r)
            CONV_IDLE: begin
               if (start_evt) begin
                  sample_r <= sample_data_in;
                  conv_cnt_r <= '0;
                  conv_state_r <= CONV_RUN;
               end
            end
            CONV_RUN: begin
               conv_cnt_r <= conv_cnt_r + 1'b1;
               if (conv_cnt_r == CNT_W'(CONV_CYC - 1)) begin
                  push_r <= 1'b1;
                  conv_state_r <= CONV_LOAD;
               end
            end
            CONV_LOAD: begin
               if (loaded_r) begin
                  handover_r <= frame_after;
                  conv_cnt_r <= CNT_W'(DATA_TO_BUSY_CYC);
                  conv_state_r <= CONV_TAIL;
               end
            end
            CONV_TAIL: begin
               if (conv_cnt_r != '0) begin
                  conv_cnt_r <= conv_cnt_r - 1'b1;
               end else begin
                  conv_state_r <= CONV_IDLE;
               end
            end
         endcase
      end
   end

   // Held result, refreshed straight from the buffer
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         result_r <= '0;
         loaded_r <= 1'b0;
      end else begin
         loaded_r <= fifo_rd_valid && fifo_rd_ready;
         if (fifo_rd_valid && fifo_rd_ready) begin
            result_r <= fifo_rd_data;
         end
      end
   end

   // Busy: read-after frames hand the falling edge to the serial side
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
      end else if (start_evt) begin
         busy_out <= 1'b1;
      end else if (conv_done && !handover_r) begin
         busy_out <= 1'b0;
      end else if (ser_done) begin
         busy_out <= 1'b0;
      end
   end

   // Parallel port
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         data_out <= '0;
         data_oe_out <= 1'b0;
      end else begin
         data_out <= result_r;
         data_oe_out <= !serial_mode_in && !cs_n_in && !rd_n_in;
      end
   end

   // Serial framing, clocking and shifting
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ser_state_r <= SER_IDLE;
         ser_cnt_r <= '0;
         bit_cnt_r <= '0;
         shreg_r <= '0;
         div_r <= 2'h0;
         sync_out <= 1'b0;
         sclk_out <= 1'b0;
         serial_data_out <= 1'b0;
      end else begin
         unique case (ser_state_r)
            SER_IDLE: begin
               sync_out <= 1'b0;
               sclk_out <= 1'b0;
               if (serial_mode_in && slave_mode_in && !cs_n_in) begin
                  shreg_r <= result_r;
                  serial_data_out <= result_r[WIDTH-1];
                  ser_state_r <= SER_SLAVE;
               end else if (frame_during || frame_after) begin
                  div_r <= read_after_in ? clock_divider_select_in : 2'h0;
                  // Held result: the buffer head has already moved past it
                  shreg_r <= result_r;
                  serial_data_out <= result_r[WIDTH-1];
                  sync_out <= 1'b1;
                  bit_cnt_r <= '0;
                  ser_cnt_r <= '0;
                  ser_state_r <= SER_LEAD;
               end
            end
            SER_LEAD: begin
               ser_cnt_r <= ser_cnt_r + 1'b1;
               if (ser_cnt_r + 1'b1 >= lead_cyc) begin
                  ser_cnt_r <= '0;
                  sclk_out <= 1'b1;
                  ser_state_r <= SER_HIGH;
               end
            end
            SER_HIGH: begin
               ser_cnt_r <= ser_cnt_r + 1'b1;
               if (ser_cnt_r + 1'b1 >= high_cyc) begin
                  ser_cnt_r <= '0;
                  sclk_out <= 1'b0;
                  bit_cnt_r <= bit_cnt_r + 1'b1;
                  shreg_r <= {shreg_r[WIDTH-2:0], 1'b0};
                  serial_data_out <= shreg_r[WIDTH-2];
                  ser_state_r <= (bit_cnt_r == 5'(WIDTH - 1)) ? SER_TAIL : SER_LOW;
               end
            end
            SER_LOW: begin
               ser_cnt_r <= ser_cnt_r + 1'b1;
               if (ser_cnt_r + 1'b1 >= low_cyc) begin
                  ser_cnt_r <= '0;
                  sclk_out <= 1'b1;
                  ser_state_r <= SER_HIGH;
               end
            end
            SER_TAIL: begin
               ser_cnt_r <= ser_cnt_r + 1'b1;
               if (ser_cnt_r + 1'b1 >= tail_cyc) begin
                  sync_out <= 1'b0;
                  ser_cnt_r <= CNT_W'(SYNC_TO_BUSY_CYC - 1);
                  ser_state_r <= read_after_in ? SER_BUSY : SER_IDLE;
               end
            end
            SER_BUSY: begin
               if (ser_cnt_r != '0) begin
                  ser_cnt_r <= ser_cnt_r - 1'b1;
               end else begin
                  ser_state_r <= SER_IDLE;
               end
            end
            SER_SLAVE: begin
               if (cs_n_in || !slave_mode_in) begin
                  ser_state_r <= SER_IDLE;
               end else if (ext_sclk_prev_r && !ext_sclk_in) begin
                  shreg_r <= {shreg_r[WIDTH-2:0], serial_data_in};
                  serial_data_out <= shreg_r[WIDTH-2];
               end
            end
            default: begin
               ser_state_r <= SER_IDLE;
            end
         endcase
      end
   end

   // Output enables follow chip select within one cycle
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         sync_oe_out <= 1'b0;
         sclk_oe_out <= 1'b0;
         serial_data_oe_out <= 1'b0;
      end else begin
         sync_oe_out <= master_mode && !cs_n_in;
         sclk_oe_out <= master_mode && !cs_n_in;
         serial_data_oe_out <= serial_mode_in && !cs_n_in;
      end
   end
endmodule : adc_conversion_readout_timing

`default_nettype wire

// file: verif/adc_readout_monitor.sv
// Port-level timing checks for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module adc_readout_monitor
   import adc_pkg::*;
#(
   parameter int WIDTH = RES_WIDTH
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic conversion_start_n_in,
   input wire logic serial_mode_in,
   input wire logic read_after_in,
   input wire logic cs_n_in,
   input wire logic rd_n_in,
   input wire logic busy_out,
   input wire logic [WIDTH-1:0] data_out,
   input wire logic data_oe_out,
   input wire logic sync_out,
   input wire logic sync_oe_out,
   input wire logic sclk_out,
   input wire logic sclk_oe_out,
   input wire logic serial_data_oe_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   wire logic ra_mode = serial_mode_in && read_after_in;
   a_busy_rise: assert property (
      $fell(conversion_start_n_in) && !busy_out && !serial_mode_in |=> busy_out)
      else $error("busy late after start");
   a_busy_width: assert property (
      $rose(busy_out) && !ra_mode |-> ##[100:125] !busy_out)
      else $error("busy high too long");
   a_data_lead: assert property (
      $fell(busy_out) && !serial_mode_in |-> $stable(data_out) && data_out == $past(data_out, 2))
      else $error("data changed near busy fall");
   a_bus_drive: assert property (
      !cs_n_in && !rd_n_in && !serial_mode_in |=> data_oe_out)
      else $error("bus not driven");
   a_bus_release: assert property (
      cs_n_in || rd_n_in || serial_mode_in |=> !data_oe_out)
      else $error("bus not released");
   a_serial_float: assert property (
      cs_n_in |=> !sync_oe_out && !sclk_oe_out && !serial_data_oe_out)
      else $error("serial pins still driven");
   a_sclk_phase: assert property (
      $rose(sclk_out) && !read_after_in |=> sclk_out ##[1:3] !sclk_out)
      else $error("serial clock high phase out of range");
   a_sync_busy: assert property (
      $fell(sync_out) && ra_mode && !cs_n_in |-> ##[2:4] $fell(busy_out))
      else $error("busy fall not tied to frame end");
endmodule : adc_readout_monitor
bind adc_conversion_readout_timing adc_readout_monitor #(.WIDTH(WIDTH)) i_mon (
   .clk_sys_in, .rst_in, .conversion_start_n_in, .serial_mode_in, .read_after_in,
   .cs_n_in, .rd_n_in, .busy_out, .data_out, .data_oe_out, .sync_out, .sync_oe_out,
   .sclk_out, .sclk_oe_out, .serial_data_oe_out);
`default_nettype wire

// file: verif/host_model.sv
// Host-side serial reader for master and slave frames
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic clk_sys_in,
   input wire logic sync_in,
   input wire logic sclk_in,
   input wire logic sdo_in,
   output logic ext_sclk_out,
   output logic [15:0] word_out
);
   logic sclk_q = 1'b0;
   initial ext_sclk_out = 1'b1;
   initial word_out = 16'h0000;
   // Master frames: one bit per rising clock, MSB first
   always @(posedge clk_sys_in) begin
      sclk_q <= sclk_in;
      if (sync_in && sclk_in && !sclk_q)
         word_out <= {word_out[14:0], sdo_in};
   end
   // Slave read: 40 ns period, clock idles high between frames
   task automatic slave_read(output logic [15:0] w);
      for (int i = 0; i < 16; i++) begin
         repeat (2) @(posedge clk_sys_in);
         w = {w[14:0], sdo_in};
         ext_sclk_out <= 1'b0;
         repeat (2) @(posedge clk_sys_in);
         ext_sclk_out <= 1'b1;
      end
   endtask : slave_read
endmodule : host_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic conversion_start_n_in = 1'b1;
   logic [15:0] sample_data_in = 16'h0000;
   logic serial_mode_in = 1'b0;
   logic slave_mode_in = 1'b0;
   logic read_after_in = 1'b0;
   logic [1:0] clock_divider_select_in = 2'h0;
   logic cs_n_in = 1'b1;
   logic rd_n_in = 1'b1;
   logic serial_data_in = 1'b0;
   wire logic ext_sclk_in, busy_out, data_oe_out, sync_out, sync_oe_out, sclk_out;
   wire logic sclk_oe_out, serial_data_out, serial_data_oe_out;
   wire logic [15:0] data_out, host_word;
   int miscompares = 0;
   int n_compared = 0;
   int sync_lag = 0;
   time t_start = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge sync_out) sync_lag = int'(($time - t_start) / 10);
   adc_conversion_readout_timing i_dut (.clk_sys_in, .rst_in, .conversion_start_n_in,
      .sample_data_in, .serial_mode_in, .slave_mode_in, .read_after_in,
      .clock_divider_select_in, .cs_n_in, .rd_n_in, .ext_sclk_in, .serial_data_in,
      .busy_out, .data_out, .data_oe_out, .sync_out, .sync_oe_out, .sclk_out,
      .sclk_oe_out, .serial_data_out, .serial_data_oe_out);
   // Released pins show the inverse of their last level
   host_model i_host (.clk_sys_in, .sync_in(sync_oe_out ? sync_out : ~sync_out),
      .sclk_in(sclk_oe_out ? sclk_out : ~sclk_out),
      .sdo_in(serial_data_oe_out ? serial_data_out : ~serial_data_out),
      .ext_sclk_out(ext_sclk_in), .word_out(host_word));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One start pulse; bw counts cycles until busy is low again
   task automatic convert(input logic [15:0] d, output int bw);
      bw = 0;
      @(posedge clk_sys_in);
      sample_data_in <= d;
      conversion_start_n_in <= 1'b0;
      @(posedge clk_sys_in);
      conversion_start_n_in <= 1'b1;
      t_start = $time;
      #1 check({15'h0, busy_out}, 16'h1);
      do begin
         @(posedge clk_sys_in);
         #1 bw++;
      end while (busy_out === 1'b1 && bw < 900);
      check(16'(bw > 1), 16'h1);
      if (serial_mode_in == 1'b0) check(data_out, d);
      repeat (100) @(posedge clk_sys_in);
   endtask : convert
   task automatic t_parallel();
      int bw;
      convert(16'ha5c3, bw);
      check(16'(bw <= 125), 16'h1);
      cs_n_in <= 1'b0;
      rd_n_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1 check(data_out, 16'ha5c3);
      check({15'h0, data_oe_out}, 16'h1);
      @(posedge clk_sys_in);
      rd_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1 check({15'h0, data_oe_out}, 16'h0);
      $display("parallel done");
   endtask : t_parallel
   task automatic t_during();
      int bw;
      @(posedge clk_sys_in);
      serial_mode_in <= 1'b1;
      convert(16'h3c5a, bw);
      check(16'(sync_lag >= 52 && sync_lag <= 54), 16'h1);
      check(host_word, 16'ha5c3);
      check(16'(bw <= 125), 16'h1);
      cs_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1 check({13'h0, sync_oe_out, sclk_oe_out, serial_data_oe_out}, 16'h0);
      $display("read during done");
   endtask : t_during
   task automatic t_after();
      int bw;
      int lim [4] = '{200, 250, 350, 575};
      int per [4] = '{40, 80, 160, 320};
      @(posedge clk_sys_in);
      read_after_in <= 1'b1;
      cs_n_in <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         clock_divider_select_in <= 2'(c);
         convert(16'(16'h8e71 + c), bw);
         check(host_word, 16'(16'h8e71 + c));
         check(16'(sync_lag >= 115 && sync_lag <= 130), 16'h1);
         check(16'(bw - sync_lag >= per[c]), 16'h1);
         check(16'(bw <= lim[c]), 16'h1);
      end
      $display("read after done");
   endtask : t_after
   task automatic t_slave();
      logic [15:0] w;
      @(posedge clk_sys_in);
      slave_mode_in <= 1'b1;
      serial_data_in <= 1'b1;
      cs_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      cs_n_in <= 1'b0;
      i_host.slave_read(w);
      check(w, 16'h8e74);
      // Chain input fills the register behind the shifted result
      i_host.slave_read(w);
      check(w, 16'hffff);
      $display("slave done");
   endtask : t_slave
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_parallel();
      t_during();
      t_after();
      t_slave();
      give_verdict();
   end
   // Tests need about 2150 cycles
   initial begin
      #100000;
      miscompares++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
